// ---- ssic_cpu.sv ----
// CPU sequencer end: runs one-cycle operations and follows the entry sequence
`timescale 1ns/1ps
module ssic_cpu (
   input wire logic clock, // 10 MHz instruction clock
   input wire logic rstn, // Asynchronous reset, active low
   input wire logic ce, // Clock enable, freezes all state when low
   ssic_if.cpu bus, // Interrupt controller side
   input wire logic op_valid, // Operation offered
   input wire ssic_pkg::ssic_op_e op_code, // Operation kind
   input wire logic [1:0] op_digit, // Control digit for bit operations
   input wire logic [1:0] op_bit, // Bit within the digit
   input wire logic [ssic_pkg::DIG_W-1:0] op_data, // Mode data, or {carry, status}
   input wire logic [ssic_pkg::PC_W-1:0] op_target, // Call target
   output logic op_ack, // Operation accepted, one-cycle pulse
   output logic [ssic_pkg::PC_W-1:0] pc, // Program counter
   output logic carry, // Carry flag
   output logic status, // Status flag
   output logic [ssic_pkg::NUM_DIG*ssic_pkg::DIG_W-1:0] ctrl_view, // Control digits
   output logic busy // Stalled by entry or return
);
   typedef struct packed {
      logic [ssic_pkg::PC_W-1:0] pc;
      logic ca;
      logic st;
      logic in_entry;
      logic in_ret;
      logic ack;
      logic bm_valid;
      logic [1:0] bm_digit;
      logic [1:0] bm_bit;
      logic bm_set;
      logic port_mode_reg_a_we;
      logic [ssic_pkg::DIG_W-1:0] port_mode_reg_a_data;
      logic call_req;
      logic [ssic_pkg::PC_W-1:0] call_pc;
      logic ret_req;
      logic ret_return_from_irq_instr;
      logic [ssic_pkg::NUM_DIG*ssic_pkg::DIG_W-1:0] view;
   } ssic_cpu_s;

   ssic_cpu_s cpu_reg;
   ssic_cpu_s cpu_next;

   // A stack operation is held off while the controller is finishing an instruction
   always_comb begin
      logic stack_op;
      logic accept;
      stack_op = (op_code == ssic_pkg::OP_CALL) || (op_code == ssic_pkg::OP_RTN)
                 || (op_code == ssic_pkg::OP_RETURN_FROM_IRQ_INSTR);
      accept = op_valid && !cpu_reg.in_entry && !cpu_reg.in_ret && !(bus.take && stack_op);
      cpu_next = cpu_reg;
      cpu_next.ack = accept;
      cpu_next.bm_valid = 1'b0;
      cpu_next.port_mode_reg_a_we = 1'b0;
      cpu_next.call_req = 1'b0;
      cpu_next.ret_req = 1'b0;
      cpu_next.view = bus.ctrl_view;
      if (accept) begin
         cpu_next.pc = cpu_reg.pc + 1'b1;
         cpu_next.bm_digit = op_digit;
         cpu_next.bm_bit = op_bit;
         cpu_next.bm_set = (op_code == ssic_pkg::OP_SET_BIT);
         case (op_code)
            ssic_pkg::OP_SET_BIT, ssic_pkg::OP_CLR_BIT: begin
               cpu_next.bm_valid = 1'b1;
            end
            ssic_pkg::OP_WR_PORT_MODE_REG_A: begin
               cpu_next.port_mode_reg_a_we = 1'b1;
               cpu_next.port_mode_reg_a_data = op_data;
            end
            ssic_pkg::OP_FLAGS: begin
               cpu_next.ca = op_data[1];
               cpu_next.st = op_data[0];
            end
            ssic_pkg::OP_CALL: begin
               cpu_next.call_req = 1'b1;
               cpu_next.call_pc = cpu_reg.pc + 1'b1;
               cpu_next.pc = op_target;
            end
            ssic_pkg::OP_RTN, ssic_pkg::OP_RETURN_FROM_IRQ_INSTR: begin
               cpu_next.ret_req = 1'b1;
               cpu_next.ret_return_from_irq_instr = (op_code == ssic_pkg::OP_RETURN_FROM_IRQ_INSTR);
               cpu_next.in_ret = 1'b1;
            end
            default: begin
            end
         endcase
      end
      // Entry: stall after cycle one, jump on the vector load
      if (bus.take) begin
         cpu_next.in_entry = 1'b1;
      end
      if (bus.vec_load) begin
         cpu_next.pc = bus.vector;
         cpu_next.in_entry = 1'b0;
      end
      if (bus.ret_valid) begin
         cpu_next.pc = bus.ret_pc;
         cpu_next.in_ret = 1'b0;
         if (bus.ret_flags) begin
            cpu_next.ca = bus.ret_ca;
            cpu_next.st = bus.ret_st;
         end
      end
   end

   // Program starts at the reset vector
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         cpu_reg <= '0;
         cpu_reg.pc <= ssic_pkg::RESET_VEC;
         cpu_reg.view <= {ssic_pkg::NUM_DIG{4'hA}};
      end else if (ce) begin
         cpu_reg <= cpu_next;
      end
   end

   assign bus.bm_valid = cpu_reg.bm_valid;
   assign bus.bm_digit = cpu_reg.bm_digit;
   assign bus.bm_bit = cpu_reg.bm_bit;
   assign bus.bm_set = cpu_reg.bm_set;
   assign bus.port_mode_reg_a_we = cpu_reg.port_mode_reg_a_we;
   assign bus.port_mode_reg_a_data = cpu_reg.port_mode_reg_a_data;
   assign bus.call_req = cpu_reg.call_req;
   assign bus.call_pc = cpu_reg.call_pc;
   assign bus.ret_req = cpu_reg.ret_req;
   assign bus.ret_return_from_irq_instr = cpu_reg.ret_return_from_irq_instr;
   assign bus.cur_pc = cpu_reg.pc;
   assign bus.cur_ca = cpu_reg.ca;
   assign bus.cur_st = cpu_reg.st;
   assign op_ack = cpu_reg.ack;
   assign pc = cpu_reg.pc;
   assign carry = cpu_reg.ca;
   assign status = cpu_reg.st;
   assign ctrl_view = cpu_reg.view;
   assign busy = cpu_reg.in_entry | cpu_reg.in_ret;
endmodule : ssic_cpu

// ---- ssic_dev.sv ----
// Interrupt controller end: flags, masks, priority, entry sequence and stack
`timescale 1ns/1ps
module ssic_dev #(
   parameter int STACK_LEVELS = 16, // Nesting depth of the stack area
   parameter int EDGE_HOLD = ssic_pkg::EDGE_HOLD_CYC // Low samples for an external edge
) (
   input wire logic clock, // 10 MHz instruction clock
   input wire logic rstn, // Asynchronous reset, active low
   input wire logic ce, // Clock enable, freezes all state when low
   ssic_if.dev bus, // CPU sequencer side
   input wire logic ext_irq_input_a_n, // External request input A, active low
   input wire logic ext_irq_input_b_n, // External request input B, active low
   input wire logic timer_a_ovf, // Timer A overflow pulse
   input wire logic timer_b_ovf, // Timer B overflow pulse
   input wire logic timer_c_ovf, // Timer C overflow pulse
   input wire logic serial_count_done, // Octal counter wrapped after eight clocks
   input wire logic serial_abort, // Octal counter reset during a transfer
   output logic timer_b_event_clk, // Timer B count pulse from input B
   output logic [ssic_pkg::SP_W-1:0] stack_ptr, // Stack pointer
   output logic irq_pending, // Enabled, unmasked request present
   output logic entry_busy // Entry sequence running
);
   localparam int LVL_W = $clog2(STACK_LEVELS);

   typedef struct packed {
      ssic_pkg::ssic_entry_e state;
      logic ie;
      logic [ssic_pkg::NUM_SRC-1:0] flag;
      logic [ssic_pkg::NUM_SRC-1:0] mask;
      logic [ssic_pkg::DIG_W-1:0] port_mode_reg_a;
      logic [ssic_pkg::SP_W-1:0] sp;
      logic [ssic_pkg::PC_W-1:0] vector;
      logic take;
      logic vec_load;
      logic ret_valid;
      logic [ssic_pkg::PC_W-1:0] ret_pc;
      logic ret_flags;
      logic ret_ca;
      logic ret_st;
      logic [ssic_pkg::NUM_DIG*ssic_pkg::DIG_W-1:0] view;
      logic tb_clk;
      logic pending;
      logic [STACK_LEVELS-1:0][ssic_pkg::WORD_W-1:0] stack;
   } ssic_dev_s;

   ssic_dev_s dev_reg;
   ssic_dev_s dev_next;
   logic [1:0] pin_n;
   logic [1:0] pin_sel;
   logic [1:0] fall;
   logic [ssic_pkg::NUM_SRC-1:0] hw_set;
   logic [ssic_pkg::NUM_SRC-1:0] req;
   logic [ssic_pkg::SEL_W:0] sel;

   // Assembles one control digit from the live bits; unused bits read zero
   function automatic logic [ssic_pkg::DIG_W-1:0] digit_of(
      input logic [1:0] d,
      input logic [ssic_pkg::NUM_SRC-1:0] flag,
      input logic [ssic_pkg::NUM_SRC-1:0] mask,
      input logic ie
   );
      logic [ssic_pkg::DIG_W-1:0] v;
      v = '0;
      for (int s = 0; s < ssic_pkg::NUM_SRC; s++) begin
         if (ssic_pkg::FLAG_DIG[s] == d) begin
            v[ssic_pkg::FLAG_BIT[s]] = flag[s];
            v[ssic_pkg::MASK_BIT[s]] = mask[s];
         end
      end
      if (d == ssic_pkg::IE_DIG) begin
         v[ssic_pkg::IE_BIT] = ie;
      end
      return v;
   endfunction : digit_of

   // Fixed priority: lowest source index wins, result is {found, index}
   function automatic logic [ssic_pkg::SEL_W:0] pick(
      input logic [ssic_pkg::NUM_SRC-1:0] r
   );
      logic [ssic_pkg::SEL_W:0] p;
      p = '0;
      for (int s = ssic_pkg::NUM_SRC - 1; s >= 0; s--) begin
         if (r[s]) begin
            p = {1'b1, ssic_pkg::SEL_W'(s)};
         end
      end
      return p;
   endfunction : pick

   assign pin_n = {ext_irq_input_b_n, ext_irq_input_a_n};
   assign pin_sel = {dev_reg.port_mode_reg_a[ssic_pkg::PORT_MODE_REG_A_EXT_B_BIT], dev_reg.port_mode_reg_a[ssic_pkg::PORT_MODE_REG_A_EXT_A_BIT]};

   // One edge detector per external pin, armed by the port mode register
   for (genvar i = 0; i < 2; i++) begin : g_edge
      ssic_edge #(
         .HOLD(EDGE_HOLD)
      ) u_edge (
         .clock(clock),
         .rstn(rstn),
         .ce(ce),
         .enable(pin_sel[i]),
         .pin_n(pin_n[i]),
         .fall(fall[i])
      );
   end

   // Hardware event sources in priority order
   assign hw_set = {serial_count_done | serial_abort, timer_c_ovf, timer_b_ovf, timer_a_ovf,
                    fall[ssic_pkg::SRC_EXT_B], fall[ssic_pkg::SRC_EXT_A]};
   assign req = dev_reg.flag & ~dev_reg.mask;
   assign sel = pick(req);

   // Next-state logic for the whole controller
   always_comb begin
      logic [ssic_pkg::SP_W-1:0] sp_up;
      logic [ssic_pkg::WORD_W-1:0] word;
      sp_up = dev_reg.sp + ssic_pkg::SP_STEP;
      word = {bus.cur_ca, bus.cur_st, bus.cur_pc};
      dev_next = dev_reg;
      dev_next.take = 1'b0;
      dev_next.vec_load = 1'b0;
      dev_next.ret_valid = 1'b0;
      // Bit manipulation: flags may only be cleared, masks and enable both ways
      if (bus.bm_valid) begin
         for (int s = 0; s < ssic_pkg::NUM_SRC; s++) begin
            if (bus.bm_digit == ssic_pkg::FLAG_DIG[s]) begin
               if (bus.bm_bit == ssic_pkg::FLAG_BIT[s] && !bus.bm_set) begin
                  dev_next.flag[s] = 1'b0;
               end
               if (bus.bm_bit == ssic_pkg::MASK_BIT[s]) begin
                  dev_next.mask[s] = bus.bm_set;
               end
            end
         end
         if (bus.bm_digit == ssic_pkg::IE_DIG && bus.bm_bit == ssic_pkg::IE_BIT) begin
            dev_next.ie = bus.bm_set;
         end
         if (bus.bm_digit == ssic_pkg::RSP_DIG && bus.bm_bit == ssic_pkg::RSP_BIT && !bus.bm_set) begin
            dev_next.sp = ssic_pkg::SP_RESET;
         end
      end
      if (bus.port_mode_reg_a_we) begin
         dev_next.port_mode_reg_a = bus.port_mode_reg_a_data;
      end
      // Applied after the software clear so a coincident event survives
      dev_next.flag = dev_next.flag | hw_set;
      dev_next.tb_clk = fall[ssic_pkg::SRC_EXT_B];
      // Stack traffic from the instruction stream, allowed while idle or finishing
      if (bus.call_req) begin
         dev_next.stack[dev_reg.sp[ssic_pkg::LVL_LSB +: LVL_W]] =
            {bus.cur_ca, bus.cur_st, bus.call_pc};
         dev_next.sp = dev_reg.sp - ssic_pkg::SP_STEP;
      end else if (bus.ret_req) begin
         word = dev_reg.stack[sp_up[ssic_pkg::LVL_LSB +: LVL_W]];
         dev_next.sp = sp_up;
         dev_next.ret_valid = 1'b1;
         dev_next.ret_pc = word[ssic_pkg::PC_W-1:0];
         dev_next.ret_ca = word[ssic_pkg::CA_POS];
         dev_next.ret_st = word[ssic_pkg::ST_POS];
         dev_next.ret_flags = bus.ret_return_from_irq_instr;
         if (bus.ret_return_from_irq_instr) begin
            dev_next.ie = 1'b1;
         end
      end
      case (dev_reg.state)
         ssic_pkg::ENT_IDLE: begin
            if (!bus.call_req && !bus.ret_req && dev_reg.ie && sel[ssic_pkg::SEL_W]) begin
               dev_next.state = ssic_pkg::ENT_FINISH;
               dev_next.take = 1'b1;
               dev_next.vector = ssic_pkg::SRC_VEC[sel[ssic_pkg::SEL_W-1:0]];
            end
         end
         ssic_pkg::ENT_FINISH: begin
            dev_next.state = ssic_pkg::ENT_SAVE_HI;
            dev_next.ie = 1'b0;
         end
         ssic_pkg::ENT_SAVE_HI: begin
            // A return finished in cycle one has not reached the CPU's PC yet
            word = {bus.cur_ca, bus.cur_st, bus.cur_pc};
            if (dev_reg.ret_valid) begin
               word[ssic_pkg::PC_W-1:0] = dev_reg.ret_pc;
               if (dev_reg.ret_flags) begin
                  word[ssic_pkg::CA_POS] = dev_reg.ret_ca;
                  word[ssic_pkg::ST_POS] = dev_reg.ret_st;
               end
            end
            dev_next.stack[dev_reg.sp[ssic_pkg::LVL_LSB +: LVL_W]]
               [ssic_pkg::WORD_W-1:ssic_pkg::HI_LSB] = word[ssic_pkg::WORD_W-1:ssic_pkg::HI_LSB];
            dev_next.state = ssic_pkg::ENT_SAVE_LO;
            dev_next.vec_load = 1'b1;
         end
         ssic_pkg::ENT_SAVE_LO: begin
            dev_next.stack[dev_reg.sp[ssic_pkg::LVL_LSB +: LVL_W]][ssic_pkg::HI_LSB-1:0] =
               bus.cur_pc[ssic_pkg::HI_LSB-1:0];
            dev_next.sp = dev_reg.sp - ssic_pkg::SP_STEP;
            dev_next.state = ssic_pkg::ENT_IDLE;
         end
         default: begin
            dev_next.state = ssic_pkg::ENT_IDLE;
         end
      endcase
      // Flags are never cleared by acceptance, only by software
      for (int d = 0; d < ssic_pkg::NUM_DIG; d++) begin
         dev_next.view[d*ssic_pkg::DIG_W +: ssic_pkg::DIG_W] =
            digit_of(2'(d), dev_next.flag, dev_next.mask, dev_next.ie);
      end
      dev_next.pending = dev_next.ie && ((dev_next.flag & ~dev_next.mask) != '0);
   end

   // Reset values: enable and flags low, every mask high
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         dev_reg <= '0;
         dev_reg.mask <= '1;
         dev_reg.view <= {ssic_pkg::NUM_DIG{4'hA}};
         dev_reg.sp <= ssic_pkg::SP_RESET;
         dev_reg.port_mode_reg_a <= ssic_pkg::PORT_MODE_REG_A_RESET;
         dev_reg.vector <= ssic_pkg::RESET_VEC;
      end else if (ce) begin
         dev_reg <= dev_next;
      end
   end

   assign bus.take = dev_reg.take;
   assign bus.vec_load = dev_reg.vec_load;
   assign bus.vector = dev_reg.vector;
   assign bus.ret_valid = dev_reg.ret_valid;
   assign bus.ret_pc = dev_reg.ret_pc;
   assign bus.ret_flags = dev_reg.ret_flags;
   assign bus.ret_ca = dev_reg.ret_ca;
   assign bus.ret_st = dev_reg.ret_st;
   assign bus.ctrl_view = dev_reg.view;
   assign timer_b_event_clk = dev_reg.tb_clk;
   assign stack_ptr = dev_reg.sp;
   assign irq_pending = dev_reg.pending;
   assign entry_busy = (dev_reg.state != ssic_pkg::ENT_IDLE);
endmodule : ssic_dev

// ---- ssic_edge.sv ----
// Falling-edge detector with a minimum low time for an external request pin
`timescale 1ns/1ps
module ssic_edge #(
   parameter int HOLD = ssic_pkg::EDGE_HOLD_CYC // Low samples needed after a high one
) (
   input wire logic clock, // Instruction clock
   input wire logic rstn, // Asynchronous reset, active low
   input wire logic ce, // Clock enable
   input wire logic enable, // Pin selected as interrupt input
   input wire logic pin_n, // Pin level, active low
   output logic fall // One-cycle pulse per accepted edge
);
   typedef struct packed {
      logic [HOLD:0] hist;
      logic fall;
   } ssic_edge_s;

   ssic_edge_s edge_reg;
   ssic_edge_s edge_next;

   // Short glitches never make the pattern, so noise cannot set a flag
   always_comb begin
      edge_next = edge_reg;
      edge_next.hist = {edge_reg.hist[HOLD-1:0], pin_n};
      edge_next.fall = enable && edge_reg.hist[HOLD] && (edge_reg.hist[HOLD-1:0] == '0);
   end

   // Idle pin level is high
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         edge_reg.hist <= '1;
         edge_reg.fall <= 1'b0;
      end else if (ce) begin
         edge_reg <= edge_next;
      end
   end

   assign fall = edge_reg.fall;
endmodule : ssic_edge

// ---- ssic_if.sv ----
// Link between the interrupt controller and the CPU sequencer
`timescale 1ns/1ps
interface ssic_if;
   logic bm_valid;
   logic [1:0] bm_digit;
   logic [1:0] bm_bit;
   logic bm_set;
   logic port_mode_reg_a_we;
   logic [ssic_pkg::DIG_W-1:0] port_mode_reg_a_data;
   logic call_req;
   logic [ssic_pkg::PC_W-1:0] call_pc;
   logic ret_req;
   logic ret_return_from_irq_instr;
   logic [ssic_pkg::PC_W-1:0] cur_pc;
   logic cur_ca;
   logic cur_st;
   logic take;
   logic vec_load;
   logic [ssic_pkg::PC_W-1:0] vector;
   logic ret_valid;
   logic [ssic_pkg::PC_W-1:0] ret_pc;
   logic ret_flags;
   logic ret_ca;
   logic ret_st;
   logic [ssic_pkg::NUM_DIG*ssic_pkg::DIG_W-1:0] ctrl_view;
   modport dev (
      input bm_valid, bm_digit, bm_bit, bm_set, port_mode_reg_a_we, port_mode_reg_a_data, call_req, call_pc,
      input ret_req, ret_return_from_irq_instr, cur_pc, cur_ca, cur_st,
      output take, vec_load, vector, ret_valid, ret_pc, ret_flags, ret_ca, ret_st, ctrl_view
   );
   modport cpu (
      output bm_valid, bm_digit, bm_bit, bm_set, port_mode_reg_a_we, port_mode_reg_a_data, call_req, call_pc,
      output ret_req, ret_return_from_irq_instr, cur_pc, cur_ca, cur_st,
      input take, vec_load, vector, ret_valid, ret_pc, ret_flags, ret_ca, ret_st, ctrl_view
   );
endinterface : ssic_if

// ---- ssic_pkg.sv ----
// Shared constants and types for the six-source interrupt control block
package ssic_pkg;
   localparam int NUM_SRC = 6;
   localparam int NUM_DIG = 4;
   localparam int DIG_W = 4;
   localparam int PC_W = 14;
   localparam int SP_W = 10;
   localparam int SEL_W = 3;
   localparam int LVL_LSB = 2;
   localparam int WORD_W = 16;
   localparam int HI_LSB = 8;
   localparam int CA_POS = 15;
   localparam int ST_POS = 14;
   localparam logic [SP_W-1:0] SP_RESET = 10'h3FF;
   localparam logic [SP_W-1:0] SP_STEP = 10'h004;
   localparam logic [PC_W-1:0] RESET_VEC = 14'h0000;
   localparam logic [1:0] IE_DIG = 2'h0;
   localparam logic [1:0] IE_BIT = 2'h0;
   localparam logic [1:0] RSP_DIG = 2'h0;
   localparam logic [1:0] RSP_BIT = 2'h1;
   // Per source in priority order: ext a, ext b, timer a, timer b, timer c, serial
   localparam int SRC_EXT_A = 0;
   localparam int SRC_EXT_B = 1;
   localparam logic [1:0] FLAG_DIG [NUM_SRC] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
   localparam logic [1:0] FLAG_BIT [NUM_SRC] = '{2'h2, 2'h0, 2'h2, 2'h0, 2'h2, 2'h0};
   localparam logic [1:0] MASK_BIT [NUM_SRC] = '{2'h3, 2'h1, 2'h3, 2'h1, 2'h3, 2'h1};
   localparam logic [PC_W-1:0] SRC_VEC [NUM_SRC] =
      '{14'h0002, 14'h0004, 14'h0006, 14'h0008, 14'h000A, 14'h000C};
   localparam logic [DIG_W-1:0] PORT_MODE_REG_A_RESET = 4'h0;
   localparam int PORT_MODE_REG_A_EXT_A_BIT = 2;
   localparam int PORT_MODE_REG_A_EXT_B_BIT = 3;
   localparam int CLK_NS = 100;
   localparam int EDGE_MIN_NS = 200;
   // Low level must be seen for more than the minimum time
   localparam int EDGE_HOLD_CYC = EDGE_MIN_NS / CLK_NS + 1;
   typedef enum logic [1:0] {ENT_IDLE, ENT_FINISH, ENT_SAVE_HI, ENT_SAVE_LO} ssic_entry_e;
   typedef enum logic [2:0] {
      OP_NOP, OP_SET_BIT, OP_CLR_BIT, OP_WR_PORT_MODE_REG_A, OP_FLAGS, OP_CALL, OP_RTN, OP_RETURN_FROM_IRQ_INSTR
   } ssic_op_e;
endpackage : ssic_pkg

// ---- ssic_props.sv ----
// Checker on the link between the interrupt controller and the sequencer
`timescale 1ns/1ps
module ssic_props (
   input wire logic clock, // Clock
   input wire logic rstn, // Reset, active low
   input wire logic take, // Entry cycle one
   input wire logic vec_load, // Entry cycle three
   input wire logic [13:0] vector, // Vector
   input wire logic bm_valid, // Bit operation
   input wire logic [1:0] bm_digit, // Digit
   input wire logic [1:0] bm_bit, // Bit
   input wire logic bm_set, // Set or clear
   input wire logic ret_valid, // Return done
   input wire logic ret_flags, // Flags restored
   input wire logic [15:0] ctrl_view // Control digits
);
   logic [13:0] best;
   logic [3:0] idx;
   // Highest unmasked request; the low numbers are looked at last so that they win
   always_comb begin
      best = 14'h0000;
      for (int s = 5; s >= 0; s--) begin
         if (ctrl_view[2*s+2] && !ctrl_view[2*s+3]) begin
            best = 14'(2*s+2);
         end
      end
   end
   assign idx = {bm_digit, bm_bit};
   default clocking @(posedge clock); endclocking
   default disable iff (!rstn);
   ent_vec_a: assert property (take |-> ##2 vec_load) else $error("no vector load");
   ent_ie_a: assert property (take |-> ##2 !ctrl_view[0]) else $error("enable kept");
   take_pulse_a: assert property (take |=> !take [*3]) else $error("take repeated");
   take_cause_a: assert property (take |-> $past(ctrl_view[0]) && $past(best) != 14'h0000)
      else $error("take without request");
   prio_vec_a: assert property (vec_load |-> vector == $past(best, 3))
      else $error("wrong vector");
   flag_keep_a: assert property (take |-> ##3 (~ctrl_view & $past(ctrl_view, 3) & 16'h1554) == 0)
      else $error("flag cleared by entry");
   sw_set_a: assert property (bm_valid && bm_set && !bm_bit[0] && idx != 4'h0
      |=> $stable(ctrl_view[$past(idx)])) else $error("software set a flag");
   mask_wr_a: assert property (bm_valid && bm_bit[0] && idx != 4'h1 && idx != 4'hF
      |=> ctrl_view[$past(idx)] == $past(bm_set)) else $error("mask not written");
   return_from_irq_instr_ie_a: assert property (ret_valid && ret_flags |-> ##[0:1] ctrl_view[0])
      else $error("enable not restored");
endmodule : ssic_props

// ---- ssic_tb.sv ----
// Bench joining both ends, with events and operations driven from outside
`timescale 1ns/1ps
module ssic_tb;
   logic clock = 1'b0;
   logic rstn = 1'b0;
   logic op_valid = 1'b0;
   ssic_pkg::ssic_op_e op_code = ssic_pkg::OP_NOP;
   logic [1:0] op_digit = 2'h0;
   logic [1:0] op_bit = 2'h0;
   logic [3:0] op_data = 4'h0;
   logic [5:0] ev = 6'h00;
   logic ab = 1'b0;
   logic ce = 1'b1;
   logic pend;
   logic tb_ev;
   int tbc = 0;
   int tbe = 0;
   logic op_ack;
   logic [9:0] sp;
   logic [13:0] pc;
   logic [15:0] cv;
   logic [15:0] pat;
   logic [31:0] rnd = 32'hC0A6609E;
   logic [15:0] vq[$];
   int fails = 0;
   int compares = 0;
   ssic_if bus_i ();
   ssic_dev u_ssic_dev (.clock(clock), .rstn(rstn), .ce(ce), .bus(bus_i),
      .ext_irq_input_a_n(!ev[0]), .ext_irq_input_b_n(!ev[1]), .timer_a_ovf(ev[2]),
      .timer_b_ovf(ev[3]), .timer_c_ovf(ev[4]), .serial_count_done(ev[5] && !ab),
      .serial_abort(ev[5] && ab), .timer_b_event_clk(tb_ev), .stack_ptr(sp),
      .irq_pending(pend), .entry_busy());
   ssic_cpu u_ssic_cpu (.clock(clock), .rstn(rstn), .ce(ce), .bus(bus_i),
      .op_valid(op_valid), .op_code(op_code), .op_digit(op_digit), .op_bit(op_bit),
      .op_data(op_data), .op_target(14'h0100), .op_ack(op_ack), .pc(pc), .carry(),
      .status(), .ctrl_view(cv), .busy());
   ssic_props u_ssic_props (.clock(clock), .rstn(rstn), .take(bus_i.take),
      .vec_load(bus_i.vec_load), .vector(bus_i.vector), .bm_valid(bus_i.bm_valid),
      .bm_digit(bus_i.bm_digit), .bm_bit(bus_i.bm_bit), .bm_set(bus_i.bm_set),
      .ret_valid(bus_i.ret_valid), .ret_flags(bus_i.ret_flags), .ctrl_view(bus_i.ctrl_view));
   // Clock, 100 ns period
   always #50 clock = ~clock;
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic stop_test;
      if (fails == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : stop_test
   // Offer one operation, hold it until acknowledged, then let it settle
   task automatic op(input ssic_pkg::ssic_op_e c, input int f, input logic [3:0] v);
      int n;
      n = 0;
      @(negedge clock);
      op_valid = 1'b1;
      op_code = c;
      op_digit = 2'(f >> 2);
      op_bit = 2'(f);
      op_data = v;
      do begin
         @(negedge clock);
         n++;
      end while (op_ack !== 1'b1 && n < 50);
      if (n >= 50) fails++;
      op_valid = 1'b0;
      repeat (4) @(negedge clock);
   endtask : op
   // Timer B count pulses from input B, sampled mid-cycle where they are settled
   always @(negedge clock) begin
      if (tb_ev === 1'b1) tbc++;
   end
   // Vectors are compared when loaded, oldest expectation first, away from the launch edge
   always @(negedge clock) begin
      if (bus_i.vec_load === 1'b1) begin
         chk({2'h0, bus_i.vector}, vq.size() > 0 ? vq.pop_front() : 16'hFFFF);
      end
   end
   // Watchdog: the whole run needs fewer than a thousand cycles
   initial begin
      repeat (30000) @(posedge clock);
      fails++;
      stop_test();
   end
   initial begin
      repeat (20) @(negedge clock);
      rstn = 1'b1;
      repeat (3) @(negedge clock);
      chk(cv, 16'h2AA8);
      chk({6'h00, sp}, 16'h03FF);
      op(ssic_pkg::OP_WR_PORT_MODE_REG_A, 0, 4'hC);
      for (int s = 0; s < 6; s++) op(ssic_pkg::OP_SET_BIT, 2 * s + 2, 4'h0);
      chk(cv & 16'h1554, 16'h0000);
      // Per source: mask the higher ones, raise random events, then enable
      for (int s = 0; s < 6; s++) begin
         op(ssic_pkg::OP_CLR_BIT, 0, 4'h0);
         for (int j = 0; j < 6; j++) begin
            op(j < s ? ssic_pkg::OP_SET_BIT : ssic_pkg::OP_CLR_BIT, 2 * j + 3, 4'h0);
         end
         rnd = lfsr(rnd);
         ab = rnd[6];
         ev = rnd[5:0] | 6'(1 << s);
         tbe += ev[1];
         pat = 16'h0000;
         for (int j = 0; j < 6; j++) pat[2*j+2] = ev[j];
         repeat (6) @(negedge clock);
         ev = 6'h00;
         repeat (6) @(negedge clock);
         chk(cv & 16'h1554, pat);
         chk({15'h0000, pend}, 16'h0000);
         vq.push_back(16'(2 * s + 2));
         op(ssic_pkg::OP_SET_BIT, 0, 4'h0);
         repeat (8) @(negedge clock);
         chk(cv & 16'h1554, pat);
         chk({6'h00, sp}, 16'h03FB);
         chk({2'h0, pc}, 16'(2 * s + 2));
         for (int j = 0; j < 6; j++) op(ssic_pkg::OP_CLR_BIT, 2 * j + 2, 4'h0);
         op(ssic_pkg::OP_RETURN_FROM_IRQ_INSTR, 0, 4'h0);
         chk({6'h00, sp}, 16'h03FF);
         chk(cv & 16'h0001, 16'h0001);
      end
      // Clock enable low: events must leave no trace in the frozen state
      ce = 1'b0;
      ev = 6'h3F;
      repeat (4) @(negedge clock);
      ev = 6'h00;
      ce = 1'b1;
      repeat (4) @(negedge clock);
      chk(cv & 16'h1554, 16'h0000);
      chk(16'(tbc), 16'(tbe));
      chk(16'(vq.size()), 16'h0000);
      stop_test();
   end
endmodule : ssic_tb
